// ===== flash_port_pkg.sv
/*
 * constants of the parallel flash programming port, used by the device end and the bench:
 * word type codes, command codes, timing counts.
 * assumes a single 25 MHz core clock on both ends.
 */
package flash_port_pkg;
	// ************************************************************
	// word type field
	// ************************************************************
	localparam logic [3:0] WORD_IS_COMMAND   = 4'h0;
	localparam logic [3:0] WORD_IS_ADDR_LOW  = 4'h1;
	localparam logic [3:0] WORD_IS_ADDR_NEXT = 4'h2;
	localparam logic [3:0] WORD_IS_DATA      = 4'h5;

	// ************************************************************
	// command codes
	// ************************************************************
	localparam logic [15:0] READ_CMD              = 16'h0011;
	localparam logic [15:0] PAGE_WRITE_CMD        = 16'h0012;
	localparam logic [15:0] PAGE_WRITE_LOCK_CMD   = 16'h0022;
	localparam logic [15:0] ERASE_WRITE_CMD       = 16'h0032;
	localparam logic [15:0] ERASE_WRITE_LOCK_CMD  = 16'h0042;
	localparam logic [15:0] ERASE_ALL_CMD         = 16'h0013;
	localparam logic [15:0] LOCK_SET_CMD          = 16'h0014;
	localparam logic [15:0] LOCK_CLEAR_CMD        = 16'h0024;
	localparam logic [15:0] LOCK_GET_CMD          = 16'h0015;
	localparam logic [15:0] NVM_BIT_SET_CMD       = 16'h0034;
	localparam logic [15:0] NVM_BIT_CLEAR_CMD     = 16'h0044;
	localparam logic [15:0] NVM_BIT_GET_CMD       = 16'h0025;
	localparam logic [15:0] SECURE_SET_CMD        = 16'h0054;
	localparam logic [15:0] SECURE_GET_CMD        = 16'h0035;
	localparam logic [15:0] MEMORY_WRITE_CMD      = 16'h001F;
	localparam logic [15:0] CONTROLLER_SELECT_CMD = 16'h0016;
	localparam logic [15:0] VERSION_GET_CMD       = 16'h001E;

	// ************************************************************
	// timing and reset values
	// ************************************************************
	localparam int          CLK_MHZ         = 25;
	localparam int          EXEC_TIME_NS    = 200;
	localparam int          EXEC_CYCLES     = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int          CLK_DET_CYCLES  = 64;
	localparam logic [15:0] CMD_RESET       = 16'h0000;
	localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
endpackage : flash_port_pkg

// ===== flash_port_if.sv
/*
 * pins of the parallel programming port, with a modport per party.
 * resolves the shared data bus here from both enables, device end first.
 */
`timescale 1ns/1ns
interface flash_port_if;
	logic        command_valid_n;
	logic [3:0]  word_type_select;
	logic        output_enable_n;
	logic        port_ready_out;
	logic        port_ready_oe;
	logic        data_valid_n;
	logic        data_valid_oe;
	logic [15:0] bus_from_host;
	logic        bus_host_oe;
	logic [15:0] bus_from_dev;
	logic        bus_dev_oe;
	logic [15:0] prog_data_bus;
	logic        test_select;
	logic        prog_enable_a;
	logic        prog_enable_b;

	// pull-ups on the data bus while nobody drives it
	assign prog_data_bus = bus_dev_oe ? bus_from_dev : (bus_host_oe ? bus_from_host : 16'hFFFF);

	modport device (
		input  command_valid_n, word_type_select, output_enable_n, prog_data_bus,
		input  test_select, prog_enable_a, prog_enable_b,
		output port_ready_out, port_ready_oe, data_valid_n, data_valid_oe, bus_from_dev, bus_dev_oe
	);
	modport host (
		output command_valid_n, word_type_select, output_enable_n, bus_from_host, bus_host_oe,
		output test_select, prog_enable_a, prog_enable_b,
		input  port_ready_out, port_ready_oe, data_valid_n, data_valid_oe, prog_data_bus
	);
endinterface : flash_port_if

// ===== flash_port_device.sv
/*
 * device end of the parallel flash programming port: handshake engine,
 * word routing, command register, address counter and page buffer flush.
 * assumes a flash array outside, reached through the user-side ports.
 */
`timescale 1ns/1ns
module flash_port_device #(
	parameter int CONTROLLERS = 2
) (
	// clock, enable and reset
	input  wire logic        core_clk,
	input  wire logic        clk_en,
	input  wire logic        reset,
	// programming port
	flash_port_if.device     port,
	// clock source
	input  wire logic        main_clock_in,
	output logic             use_external_clock,
	// flash side
	output logic             flash_read,
	output logic             flash_write,
	output logic             flash_flush,
	output logic             flash_exec,
	output logic [15:0]      flash_cmd,
	output logic [31:0]      flash_addr,
	output logic [15:0]      flash_wdata,
	input  wire logic [15:0] flash_rdata,
	input  wire logic        flash_busy
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [5:0]  sync1_q, sync2_q;
	logic [3:0]  mode1_q, mode2_q;
	logic [15:0] data1_q, data2_q;
	logic [2:0]  xin_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= 6'h3F;
			sync2_q <= 6'h3F;
			mode1_q <= 4'hF;
			mode2_q <= 4'hF;
			data1_q <= 16'hFFFF;
			data2_q <= 16'hFFFF;
			xin_q   <= 3'h0;
		end else if (clk_en) begin
			sync1_q <= {port.command_valid_n, port.output_enable_n, port.test_select,
			            port.prog_enable_a, port.prog_enable_b, 1'b0};
			sync2_q <= sync1_q;
			mode1_q <= port.word_type_select;
			mode2_q <= mode1_q;
			data1_q <= port.prog_data_bus;
			data2_q <= data1_q;
			xin_q   <= {xin_q[1:0], main_clock_in};
		end
	end
	wire cmd_n = sync2_q[5];
	wire oe_n  = sync2_q[4];
	wire prog_mode = sync2_q[3] & sync2_q[2] & sync2_q[1];

	// ************************************************************
	// decoding
	// ************************************************************
	function automatic logic is_write_cmd(input logic [15:0] c);
		is_write_cmd = (c == flash_port_pkg::PAGE_WRITE_CMD) ||
		               (c == flash_port_pkg::PAGE_WRITE_LOCK_CMD) ||
		               (c == flash_port_pkg::ERASE_WRITE_CMD) ||
		               (c == flash_port_pkg::ERASE_WRITE_LOCK_CMD) ||
		               (c == flash_port_pkg::MEMORY_WRITE_CMD);
	endfunction : is_write_cmd
	function automatic logic is_exec_cmd(input logic [15:0] c);
		is_exec_cmd = (c == flash_port_pkg::ERASE_ALL_CMD) ||
		              (c == flash_port_pkg::LOCK_SET_CMD) ||
		              (c == flash_port_pkg::LOCK_CLEAR_CMD) ||
		              (c == flash_port_pkg::NVM_BIT_SET_CMD) ||
		              (c == flash_port_pkg::NVM_BIT_CLEAR_CMD) ||
		              (c == flash_port_pkg::SECURE_SET_CMD) ||
		              ((c == flash_port_pkg::CONTROLLER_SELECT_CMD) && (CONTROLLERS > 1));
	endfunction : is_exec_cmd

	logic [15:0] cmd_q;
	logic [31:0] addr_q;
	logic [3:0]  mode_q;
	wire sel_cmd   = mode_q == flash_port_pkg::WORD_IS_COMMAND;
	wire sel_alow  = mode_q == flash_port_pkg::WORD_IS_ADDR_LOW;
	wire sel_anext = mode_q == flash_port_pkg::WORD_IS_ADDR_NEXT;
	wire sel_data  = mode_q == flash_port_pkg::WORD_IS_DATA;
	wire read_cmd  = (cmd_q == flash_port_pkg::READ_CMD) ||
	                 (cmd_q == flash_port_pkg::LOCK_GET_CMD) ||
	                 (cmd_q == flash_port_pkg::NVM_BIT_GET_CMD) ||
	                 (cmd_q == flash_port_pkg::SECURE_GET_CMD) ||
	                 (cmd_q == flash_port_pkg::VERSION_GET_CMD);
	wire data_read = sel_data && read_cmd;

	// ************************************************************
	// clock source detect
	// ************************************************************
	logic [6:0] edge_cnt_q;
	logic       ext_seen_q;
	wire xin_edge = xin_q[2] ^ xin_q[1];
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			edge_cnt_q <= 7'h00;
			ext_seen_q <= 1'b0;
		end else if (clk_en && xin_edge && !ext_seen_q) begin
			edge_cnt_q <= edge_cnt_q + 7'h01;
			ext_seen_q <= edge_cnt_q == 7'(flash_port_pkg::CLK_DET_CYCLES);
		end
	end

	// ************************************************************
	// handshake engine
	// ************************************************************
	typedef enum logic [2:0] {IDLE, LATCH, EXEC, WAIT_OE, DRIVE, WAIT_OEH, WAIT_CMD} hs_e;
	hs_e  st_q;
	logic [7:0] tmr_q;
	logic started_q;
	logic [15:0] rdat_q;
	wire exec_done = (tmr_q == 8'(flash_port_pkg::EXEC_CYCLES)) && !flash_busy;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_q <= IDLE;
			cmd_q <= flash_port_pkg::CMD_RESET;
			addr_q <= flash_port_pkg::ADDR_RESET;
			mode_q <= 4'h0;
			tmr_q <= 8'h00;
			started_q <= 1'b0;
			rdat_q <= 16'h0000;
			use_external_clock <= 1'b0;
			port.port_ready_out <= 1'b1;
			port.port_ready_oe <= 1'b0;
			port.data_valid_n <= 1'b1;
			port.data_valid_oe <= 1'b0;
			port.bus_from_dev <= 16'h0000;
			port.bus_dev_oe <= 1'b0;
			flash_read <= 1'b0;
			flash_write <= 1'b0;
			flash_flush <= 1'b0;
			flash_exec <= 1'b0;
			flash_cmd <= flash_port_pkg::CMD_RESET;
			flash_addr <= flash_port_pkg::ADDR_RESET;
			flash_wdata <= 16'h0000;
		end else if (clk_en) begin
			flash_read <= 1'b0;
			flash_write <= 1'b0;
			flash_flush <= 1'b0;
			flash_exec <= 1'b0;
			unique case (st_q)
			IDLE: begin
				if (prog_mode && !cmd_n) begin
					if (!started_q)
						use_external_clock <= ext_seen_q;
					started_q <= 1'b1;
					mode_q <= mode2_q;
					port.port_ready_oe <= 1'b1;
					port.data_valid_oe <= 1'b1;
					port.port_ready_out <= 1'b0;
					tmr_q <= 8'h00;
					flash_wdata <= data2_q;
					st_q <= LATCH;
				end
			end
			LATCH: begin
				if (sel_cmd) begin
					cmd_q <= flash_wdata;
					flash_cmd <= flash_wdata;
					flash_flush <= 1'b1;
					flash_exec <= is_exec_cmd(flash_wdata);
				end else if (sel_alow)
					addr_q[15:0] <= flash_wdata;
				else if (sel_anext)
					addr_q[31:16] <= flash_wdata;
				else if (sel_data && !read_cmd)
					flash_write <= is_write_cmd(cmd_q);
				// other word types touch nothing
				flash_addr <= addr_q;
				flash_read <= data_read;
				st_q <= data_read ? WAIT_OE : EXEC;
			end
			EXEC: begin
				if (tmr_q != 8'(flash_port_pkg::EXEC_CYCLES))
					tmr_q <= tmr_q + 8'h01;
				if (exec_done) begin
					if (sel_data)
						addr_q <= addr_q + 32'h2;
					st_q <= WAIT_CMD;
				end
			end
			WAIT_OE: begin
				rdat_q <= flash_rdata;
				if (!oe_n && !flash_busy)
					st_q <= DRIVE;
			end
			DRIVE: begin
				port.bus_from_dev <= rdat_q;
				port.bus_dev_oe <= 1'b1;
				port.data_valid_n <= 1'b0;
				st_q <= WAIT_OEH;
			end
			WAIT_OEH: begin
				if (oe_n) begin
					port.bus_dev_oe <= 1'b0;
					port.data_valid_n <= 1'b1;
					addr_q <= addr_q + 32'h2;
					st_q <= WAIT_CMD;
				end
			end
			WAIT_CMD: begin
				if (cmd_n) begin
					port.port_ready_out <= 1'b1;
					st_q <= IDLE;
				end
			end
			default: st_q <= IDLE;
			endcase
		end
	end
endmodule : flash_port_device

// ===== flash_port_host.sv
/*
 * programmer end of the parallel flash programming port: runs one write or
 * read handshake per user request after the power-on wait.
 * assumes the device end on the far side of the interface.
 */
`timescale 1ns/1ns
module flash_port_host #(
	parameter int POR_CYCLES = 5000
) (
	// clock, enable and reset
	input  wire logic        core_clk,
	input  wire logic        clk_en,
	input  wire logic        reset,
	// programming port
	flash_port_if.host       port,
	// user request
	input  wire logic        req_valid,
	input  wire logic        req_read,
	input  wire logic [3:0]  req_mode,
	input  wire logic [15:0] req_data,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [15:0]      rsp_data
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [1:0] s1_q, s2_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
		end else if (clk_en) begin
			// an undriven ready line reads high through its pull-up, else nothing could start
			s1_q <= {port.port_ready_out | ~port.port_ready_oe, port.data_valid_n | ~port.data_valid_oe};
			s2_q <= s1_q;
		end
	end
	wire rdy = s2_q[1];
	wire valid_n = s2_q[0];

	// ************************************************************
	// handshake sequencer
	// ************************************************************
	typedef enum logic [2:0] {POR, IDLE, WAIT_BUSY, WAIT_VALID, WAIT_REL, WAIT_RDY} hst_e;
	hst_e st_q;
	logic [31:0] por_q;
	logic        rd_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_q <= POR;
			por_q <= 32'h0;
			rd_q <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			port.command_valid_n <= 1'b1;
			port.word_type_select <= 4'hF;
			port.output_enable_n <= 1'b1;
			port.bus_from_host <= 16'h0000;
			port.bus_host_oe <= 1'b0;
			port.test_select <= 1'b1;
			port.prog_enable_a <= 1'b1;
			port.prog_enable_b <= 1'b1;
		end else if (clk_en) begin
			rsp_valid <= 1'b0;
			unique case (st_q)
			POR: begin
				por_q <= por_q + 32'h1;
				if (por_q == 32'(POR_CYCLES)) begin
					req_ready <= 1'b1;
					st_q <= IDLE;
				end
			end
			IDLE: begin
				if (req_valid && rdy) begin
					req_ready <= 1'b0;
					rd_q <= req_read;
					port.word_type_select <= req_mode;
					port.bus_from_host <= req_data;
					port.bus_host_oe <= 1'b1;
					port.command_valid_n <= 1'b0;
					st_q <= WAIT_BUSY;
				end
			end
			WAIT_BUSY: begin
				if (!rdy) begin
					port.bus_host_oe <= 1'b0;
					if (rd_q) begin
						port.output_enable_n <= 1'b0;
						st_q <= WAIT_VALID;
					end else begin
						port.command_valid_n <= 1'b1;
						st_q <= WAIT_RDY;
					end
				end
			end
			WAIT_VALID: begin
				if (!valid_n) begin
					rsp_data <= port.prog_data_bus;
					rsp_valid <= 1'b1;
					port.output_enable_n <= 1'b1;
					st_q <= WAIT_REL;
				end
			end
			WAIT_REL: begin
				if (valid_n) begin
					port.command_valid_n <= 1'b1;
					st_q <= WAIT_RDY;
				end
			end
			WAIT_RDY: begin
				if (rdy) begin
					req_ready <= 1'b1;
					st_q <= IDLE;
				end
			end
			default: st_q <= POR;
			endcase
		end
	end
endmodule : flash_port_host

// ===== flash_port_properties.sv
/*
 * concurrent checks on the programming port pins between host and device ends.
 * assumes one core clock, asynchronous active-high reset, pins seen as plain inputs.
 */
`timescale 1ns/1ns
module flash_port_properties #(
	parameter int POR_CYCLES = 5000
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// host driven
	input wire logic command_valid_n,
	input wire logic output_enable_n,
	input wire logic bus_host_oe,
	input wire logic test_select,
	input wire logic prog_enable_a,
	input wire logic prog_enable_b,
	// device driven
	input wire logic port_ready_out,
	input wire logic port_ready_oe,
	input wire logic data_valid_n,
	input wire logic data_valid_oe,
	input wire logic bus_dev_oe
);
	// ************************************************************
	// helper logic
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [31:0] por_cnt_q;
	// saturates, so a long run never wraps back into the quiet window
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			por_cnt_q <= 32'h0000_0000;
		end else if (por_cnt_q < 32'(POR_CYCLES)) begin
			por_cnt_q <= por_cnt_q + 32'h0000_0001;
		end
	end
	sequence s_drive_answer;
		##[1:8] (!data_valid_n && data_valid_oe && bus_dev_oe);
	endsequence
	sequence s_release;
		##[1:8] (!bus_dev_oe && data_valid_n);
	endsequence

	// ************************************************************
	// properties
	// ************************************************************
	a_undriven_after_reset: assert property ($fell(reset) |-> !bus_dev_oe && !data_valid_oe && !port_ready_oe)
		else $error("port line driven right after reset");
	a_por_quiet_wait: assert property (por_cnt_q < 32'(POR_CYCLES) |-> command_valid_n)
		else $error("handshake started inside power-on wait");
	a_selects_held_high: assert property (test_select && prog_enable_a && prog_enable_b)
		else $error("mode selects not high");
	a_ready_falls_take: assert property ($fell(command_valid_n) |-> ##[1:8] (port_ready_oe && !port_ready_out))
		else $error("ready did not fall after command strobe");
	a_exec_min_busy: assert property ($fell(port_ready_out) |-> !port_ready_out [*5])
		else $error("ready rose before execution time");
	a_ready_after_release: assert property ($rose(port_ready_out) && $past(port_ready_oe)
		|-> $past(command_valid_n) && $past(command_valid_n, 2))
		else $error("ready rose while strobe still low");
	a_read_drive_answer: assert property ($fell(output_enable_n) |-> s_drive_answer)
		else $error("device did not drive bus after output enable");
	a_read_release_bus: assert property ($rose(output_enable_n) |-> s_release)
		else $error("device did not release bus");
	a_valid_means_drive: assert property (data_valid_oe && !data_valid_n |-> bus_dev_oe)
		else $error("valid low while bus not driven");
	a_no_bus_contention: assert property (!(bus_host_oe && bus_dev_oe))
		else $error("both ends drive data bus");
	c_read_done: cover property ($rose(data_valid_n));
endmodule : flash_port_properties

// ===== tb_parallel_flash_programming_port.sv
/*
 * self-checking bench: host and device ends joined by the port interface.
 * assumes the flash array answers with a word derived from its address.
 */
`timescale 1ns/1ns
module tb_parallel_flash_programming_port;
	// ************************************************************
	// signals
	// ************************************************************
	localparam int POR = 20;
	localparam logic [15:0] CODES [17] = '{flash_port_pkg::READ_CMD, flash_port_pkg::PAGE_WRITE_CMD,
		flash_port_pkg::PAGE_WRITE_LOCK_CMD, flash_port_pkg::ERASE_WRITE_CMD, flash_port_pkg::ERASE_WRITE_LOCK_CMD,
		flash_port_pkg::ERASE_ALL_CMD, flash_port_pkg::LOCK_SET_CMD, flash_port_pkg::LOCK_CLEAR_CMD,
		flash_port_pkg::LOCK_GET_CMD, flash_port_pkg::NVM_BIT_SET_CMD, flash_port_pkg::NVM_BIT_CLEAR_CMD,
		flash_port_pkg::NVM_BIT_GET_CMD, flash_port_pkg::SECURE_SET_CMD, flash_port_pkg::SECURE_GET_CMD,
		flash_port_pkg::MEMORY_WRITE_CMD, flash_port_pkg::CONTROLLER_SELECT_CMD, flash_port_pkg::VERSION_GET_CMD};
	logic        core_clk   = 1'b0;
	logic        reset      = 1'b1;
	logic        req_valid  = 1'b0;
	logic        req_read   = 1'b0;
	logic [3:0]  req_mode   = 4'h0;
	logic [15:0] req_data   = 16'h0000;
	logic        flash_busy = 1'b0;
	logic [15:0] rnd        = 16'h0048;
	logic [15:0] brnd       = 16'h0048;
	logic        main_clock_in = 1'b0;
	logic        xin_run    = 1'b0;
	logic        req_ready, rsp_valid, use_external_clock, flash_read, flash_write, flash_flush, flash_exec;
	logic [15:0] rsp_data, flash_cmd, flash_wdata;
	logic [31:0] flash_addr;
	logic [15:0] exp_q [$];
	int          n_fail   = 0;
	int          n_checks = 0;
	int          n_flush  = 0;
	int          n_exec   = 0;
	int          n_write  = 0;
	int          n_read   = 0;
	// array answer ties read data to the full address, so both halves are seen
	wire  [15:0] flash_rdata = flash_addr[15:0] ^ flash_addr[31:16];

	always #20 core_clk = ~core_clk;
	// external clock toggles off the core clock edges, so every toggle is sampled once
	initial begin
		#5;
		forever #50 main_clock_in = xin_run & ~main_clock_in;
	end

	flash_port_if flash_port_if_inst ();
	flash_port_device #(.CONTROLLERS(2)) flash_port_device_inst (.core_clk(core_clk), .clk_en(1'b1),
		.reset(reset), .port(flash_port_if_inst), .main_clock_in(main_clock_in), .use_external_clock(use_external_clock),
		.flash_read(flash_read), .flash_write(flash_write), .flash_flush(flash_flush), .flash_exec(flash_exec),
		.flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
		.flash_busy(flash_busy));
	flash_port_host #(.POR_CYCLES(POR)) flash_port_host_inst (.core_clk(core_clk), .clk_en(1'b1), .reset(reset),
		.port(flash_port_if_inst), .req_valid(req_valid), .req_read(req_read), .req_mode(req_mode),
		.req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
	flash_port_properties #(.POR_CYCLES(POR)) flash_port_properties_inst (.core_clk(core_clk), .reset(reset),
		.command_valid_n(flash_port_if_inst.command_valid_n), .output_enable_n(flash_port_if_inst.output_enable_n),
		.bus_host_oe(flash_port_if_inst.bus_host_oe), .test_select(flash_port_if_inst.test_select),
		.prog_enable_a(flash_port_if_inst.prog_enable_a), .prog_enable_b(flash_port_if_inst.prog_enable_b),
		.port_ready_out(flash_port_if_inst.port_ready_out), .port_ready_oe(flash_port_if_inst.port_ready_oe),
		.data_valid_n(flash_port_if_inst.data_valid_n), .data_valid_oe(flash_port_if_inst.data_valid_oe),
		.bus_dev_oe(flash_port_if_inst.bus_dev_oe));

	// ************************************************************
	// tasks
	// ************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic wrap_up();
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wait_ready();
		int i;
		i = 0;
		while (req_ready !== 1'b1) begin
			if (i++ == 400) begin
				check("req_ready", 32'h1, {31'h0, req_ready});
				wrap_up();
			end
			@(posedge core_clk);
			#2;
		end
	endtask : wait_ready

	// one whole handshake: request held until taken, then wait for completion
	task automatic send(input logic rd, input logic [3:0] mode, input logic [15:0] data);
		int i;
		wait_ready();
		i = 0;
		req_valid = 1'b1;
		req_read  = rd;
		req_mode  = mode;
		req_data  = data;
		do begin
			@(posedge core_clk);
			#2;
			if (i++ == 400) begin
				check("req_taken", 32'h0, {31'h0, req_ready});
				wrap_up();
			end
		end while (req_ready !== 1'b0);
		req_valid = 1'b0;
		wait_ready();
	endtask : send

	// ************************************************************
	// monitors
	// ************************************************************
	// busy never stands two cycles running, so read answers keep their bound
	always @(posedge core_clk) begin
		#2;
		brnd = lfsr(brnd);
		flash_busy = !flash_busy & brnd[0] & brnd[3];
	end
	always @(posedge core_clk) begin
		if (flash_flush === 1'b1) begin
			n_flush++;
		end
		n_exec  += int'(flash_exec === 1'b1);
		n_write += int'(flash_write === 1'b1);
		n_read  += int'(flash_read === 1'b1);
		if (rsp_valid === 1'b1) begin
			check("rsp_data", exp_q.size() > 0 ? {16'h0000, exp_q.pop_front()} : 32'hFFFF_FFFF, {16'h0000, rsp_data});
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [31:0] base, a0, a;
		int          nf;
		repeat (16) @(posedge core_clk);
		#2;
		check("dev_oe", 32'h0, {29'h0, flash_port_if_inst.port_ready_oe, flash_port_if_inst.data_valid_oe,
			flash_port_if_inst.bus_dev_oe});
		check("bus", 32'h0000_FFFF, {16'h0000, flash_port_if_inst.prog_data_bus});
		reset = 1'b0;
		foreach (CODES[i]) begin
			send(1'b0, flash_port_pkg::WORD_IS_COMMAND, CODES[i]);
			check("flash_cmd", {16'h0000, CODES[i]}, {16'h0000, flash_cmd});
		end
		a0 = flash_addr;
		for (int m = 3; m < 16; m++) begin
			rnd = lfsr(rnd);
			if (m != 5) send(1'b0, 4'(m), rnd);
		end
		check("flash_cmd", {16'h0000, flash_port_pkg::VERSION_GET_CMD}, {16'h0000, flash_cmd});
		check("flash_addr", a0, flash_addr);
		send(1'b0, flash_port_pkg::WORD_IS_COMMAND, flash_port_pkg::READ_CMD);
		rnd = lfsr(rnd);
		base[15:0] = rnd;
		rnd = lfsr(rnd);
		base[31:16] = rnd;
		send(1'b0, flash_port_pkg::WORD_IS_ADDR_LOW, base[15:0]);
		send(1'b0, flash_port_pkg::WORD_IS_ADDR_NEXT, base[31:16]);
		send(1'b0, 4'h7, ~base[15:0]);
		check("flash_addr", base, flash_addr);
		// chained reads with no new address in between
		for (int i = 0; i < 3; i++) begin
			a = base + 32'(2 * i);
			exp_q.push_back(a[15:0] ^ a[31:16]);
			send(1'b1, flash_port_pkg::WORD_IS_DATA, 16'h0000);
		end
		send(1'b0, flash_port_pkg::WORD_IS_COMMAND, flash_port_pkg::PAGE_WRITE_CMD);
		send(1'b0, flash_port_pkg::WORD_IS_ADDR_LOW, base[15:0]);
		send(1'b0, flash_port_pkg::WORD_IS_ADDR_NEXT, base[31:16]);
		nf = n_flush;
		for (int i = 0; i < 2; i++) begin
			rnd = lfsr(rnd);
			send(1'b0, flash_port_pkg::WORD_IS_DATA, rnd);
			check("flash_wdata", {16'h0000, rnd}, {16'h0000, flash_wdata});
			check("flash_addr", base + 32'(2 * i), flash_addr);
		end
		send(1'b0, flash_port_pkg::WORD_IS_COMMAND, flash_port_pkg::READ_CMD);
		check("flash_addr", base + 32'h0000_0004, flash_addr);
		check("flush", nf + 1, n_flush);
		check("ext_clk", 32'h0, {31'h0, use_external_clock});
		check("exp_q", 32'h0, exp_q.size());
		// second reset, external clock running well before the first handshake
		reset = 1'b1;
		xin_run = 1'b1;
		@(posedge core_clk);
		#2;
		check("dev_oe", 32'h0, {29'h0, flash_port_if_inst.port_ready_oe, flash_port_if_inst.data_valid_oe,
			flash_port_if_inst.bus_dev_oe});
		reset = 1'b0;
		repeat (120) @(posedge core_clk);
		#2;
		send(1'b0, flash_port_pkg::WORD_IS_COMMAND, flash_port_pkg::READ_CMD);
		check("flash_cmd", {16'h0000, flash_port_pkg::READ_CMD}, {16'h0000, flash_cmd});
		check("ext_clk", 32'h1, {31'h0, use_external_clock});
		check("flash_exec", 32'h7, n_exec);
		check("flash_write", 32'h2, n_write);
		check("flash_read", 32'h3, n_read);
		wrap_up();
	end
endmodule : tb_parallel_flash_programming_port
